/* File: logic/sesl_pkg.sv */
package sesl_pkg;
    // Command identifiers and the global bus address.
    localparam logic [3:0] CMD_DISABLE_ST = 4'hC;
    localparam logic [3:0] CMD_ENABLE_ST  = 4'hD;
    localparam logic [3:0] CMD_UNUSED_14  = 4'hE;
    localparam logic [3:0] CMD_REV_INIT   = 4'hF;
    localparam logic [3:0] CMD_CLEAR      = 4'h1;
    localparam logic [3:0] CMD_READ_ACCEL = 4'h8;
    localparam logic [3:0] GLOBAL_ADDR    = 4'h0;

    // Timing.
    localparam int CLK_MHZ                    = 125;
    localparam int HOLD_CAP_RESET_INTERVAL_US = 100;
    localparam int CAP_TEST_RESET_INTERVAL_US = 200;
    localparam int FRAME_IDLE_LIMIT_US        = 50;
    localparam int HOLD_CAP_RESET_CYC = HOLD_CAP_RESET_INTERVAL_US * CLK_MHZ;
    localparam int CAP_TEST_RESET_CYC = CAP_TEST_RESET_INTERVAL_US * CLK_MHZ;
    localparam int FRAME_IDLE_CYC     = FRAME_IDLE_LIMIT_US * CLK_MHZ;
    localparam int TMR_W              = 16;
    localparam logic [2:0] NO_ANSWER_WAIT = 3'h4;

    // Response status field positions.
    localparam int RSP_S_BIT   = 1;
    localparam int RSP_AT_LSB  = 2;
    localparam int RSP_ST_BIT  = 5;
    localparam int RSP_U_BIT   = 6;
    localparam int RSP_NV_BIT  = 7;
    localparam int RSP_ADR_LSB = 12;

    // Controller registers (byte addresses).
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RSP    = 4'h8;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_ADDR_LSB = 4;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_LONG_BIT = 16;
    localparam int STS_RSP_BIT  = 0;
    localparam int STS_NOANS_BIT = 1;
    localparam int STS_LONG_BIT = 2;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* File: logic/sesl_link_if.sv */
`timescale 1ns/1ps
interface sesl_link_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic        cmd_valid;
    logic        cmd_long;
    logic [3:0]  cmd_code;
    logic [3:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic        rsp_valid;
    logic        rsp_long;
    logic [15:0] rsp_data;

    modport dev (
        input  aclk, aresetn, cmd_valid, cmd_long, cmd_code, cmd_addr,
               cmd_data,
        output rsp_valid, rsp_long, rsp_data
    );
    modport ctl (
        input  aclk, aresetn, rsp_valid, rsp_long, rsp_data,
        output cmd_valid, cmd_long, cmd_code, cmd_addr, cmd_data
    );
endinterface

/* File: logic/sesl_interval_timer.sv */
`timescale 1ns/1ps
module sesl_interval_timer
    import sesl_pkg::*;
#(
    parameter int CYCLES = 1000
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic cond,
    output logic      fire
);
    logic [TMR_W-1:0] cnt;

    // Fires once per full interval while the condition persists.
    always_ff @(posedge aclk) begin
        if (!aresetn || !cond || fire) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fire <= 1'b0;
        end else begin
            fire <= cond && !fire && (cnt == TMR_W'(CYCLES - 2));
        end
    end
endmodule

/* File: logic/sesl_device.sv */
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module sesl_device
    import sesl_pkg::*;
#(
    parameter int HOLD_CAP_PIN_CYC  = HOLD_CAP_RESET_CYC,
    parameter int CTEST_CYC = CAP_TEST_RESET_CYC,
    parameter int IDLE_CYC  = FRAME_IDLE_CYC
) (
    sesl_link_if.dev    link,
    input  wire logic        vreg_low,
    input  wire logic        vrega_low,
    input  wire logic        hold_cap_pin,
    input  wire logic        cap_test_fail,
    input  wire logic        line_input_pin,
    input  wire logic        factory_crc_fail,
    input  wire logic        factory_seal,
    input  wire logic        user_mismatch,
    input  wire logic        user_seal,
    input  wire logic        otp_write_enabled_flag,
    input  wire logic [7:0]  device_config_one,
    input  wire logic [3:0]  bus_address,
    input  wire logic [15:0] accel_normal,
    input  wire logic [15:0] accel_self_test,
    output logic             self_test_drive,
    output logic             core_in_reset
);
    logic       aclk;
    logic       aresetn;
    logic [8:0] sync_a;
    logic [8:0] sync_b;
    logic       s_vreg;
    logic       s_vrega;
    logic       s_hold_cap_pin_low;
    logic       s_ctest;
    logic       s_line_low;
    logic       s_fcrc;
    logic       s_fseal;
    logic       s_umis;
    logic       s_useal;
    logic       hold_cap_pin_fire;
    logic       ctest_fire;
    logic       idle_fire;
    logic       hold_cap_pin_mode;
    logic       ctest_mode;
    logic       idle_mode;
    logic       core_rst;
    logic       silent;
    logic       st_active;
    logic       lockout;
    logic       last_was_disable;
    logic       addressed;
    logic       act;
    logic       fault;
    logic       err_flag;
    logic [15:0] status_word;
    logic [15:0] short_accel;
    logic [15:0] long_accel;
    logic [15:0] next_rsp;

    assign aclk    = link.aclk;
    assign aresetn = link.aresetn;

    // Analogue comparator levels arrive asynchronously.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {vreg_low, vrega_low, hold_cap_pin, cap_test_fail,
                       line_input_pin, factory_crc_fail, factory_seal,
                       user_mismatch, user_seal};
            sync_b <= sync_a;
        end
    end

    assign {s_vreg, s_vrega, s_hold_cap_pin_low, s_ctest, s_line_low, s_fcrc,
            s_fseal, s_umis, s_useal} = sync_b;

    sesl_interval_timer #(.CYCLES(HOLD_CAP_PIN_CYC)) u_hold_cap_pin_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cond    (s_hold_cap_pin_low),
        .fire    (hold_cap_pin_fire)
    );

    sesl_interval_timer #(.CYCLES(CTEST_CYC)) u_ctest_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cond    (s_ctest),
        .fire    (ctest_fire)
    );

    sesl_interval_timer #(.CYCLES(IDLE_CYC)) u_idle_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cond    (s_line_low),
        .fire    (idle_fire)
    );

    // Regulator faults hold reset; the interval timers pulse it.
    assign core_rst = !aresetn || s_vreg || s_vrega
                      || hold_cap_pin_fire
                      || ctest_fire
                      || idle_fire;

    // A mode stays set from its first reset pulse until the cause clears,
    // so the device keeps quiet between the repeated resets.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_cap_pin_mode  <= 1'b0;
            ctest_mode <= 1'b0;
            idle_mode  <= 1'b0;
        end else begin
            hold_cap_pin_mode  <= s_hold_cap_pin_low && (hold_cap_pin_mode || hold_cap_pin_fire);
            ctest_mode <= s_ctest && (ctest_mode || ctest_fire);
            idle_mode  <= s_line_low && (idle_mode || idle_fire);
        end
    end

    assign silent = core_rst || hold_cap_pin_mode || ctest_mode || idle_mode;
    assign core_in_reset = silent;

    assign addressed = link.cmd_valid && !silent
                       && (link.cmd_addr == bus_address);
    // Identifiers E and F take no action at all.
    assign act = addressed && (link.cmd_code != CMD_UNUSED_14)
                 && (link.cmd_code != CMD_REV_INIT);

    always_ff @(posedge aclk) begin
        if (core_rst) begin
            st_active <= 1'b0;
        end else if (act && link.cmd_code == CMD_ENABLE_ST
                     && link.cmd_addr != GLOBAL_ADDR
                     && !lockout) begin
            st_active <= 1'b1;
        end else if (act && (link.cmd_code == CMD_DISABLE_ST
                     || link.cmd_code == CMD_CLEAR)) begin
            st_active <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (core_rst || s_hold_cap_pin_low) begin
            lockout <= 1'b0;
        end else if (act && link.cmd_code == CMD_CLEAR) begin
            lockout <= 1'b0;
        end else if (act && link.cmd_code == CMD_DISABLE_ST
                     && last_was_disable) begin
            lockout <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (core_rst) begin
            last_was_disable <= 1'b0;
        end else if (act) begin
            last_was_disable <= (link.cmd_code == CMD_DISABLE_ST);
        end
    end

    assign self_test_drive = st_active;

    // A dip masks the self-test part of the error flag.
    assign fault = (s_fcrc && s_fseal)
                   || (s_umis && s_useal);
    assign err_flag = fault
                      || (st_active && !s_hold_cap_pin_low);

    always_comb begin
        status_word = '0;
        status_word[RSP_S_BIT]  = err_flag;
        status_word[RSP_AT_LSB +: 2] = device_config_one[1:0];
        status_word[RSP_ST_BIT] = st_active;
        status_word[RSP_U_BIT]  = s_hold_cap_pin_low;
        status_word[RSP_NV_BIT] = otp_write_enabled_flag;
    end

    always_comb begin
        if (fault) begin
            short_accel = '0;
        end else if (st_active) begin
            short_accel = accel_self_test;
        end else if (s_hold_cap_pin_low) begin
            short_accel = '0;
        end else begin
            short_accel = accel_normal;
        end
        if (st_active) begin
            long_accel = accel_self_test;
        end else begin
            long_accel = accel_normal;
        end
    end

    always_comb begin
        if (link.cmd_code == CMD_READ_ACCEL) begin
            next_rsp = link.cmd_long ? long_accel : short_accel;
        end else if (link.cmd_long) begin
            next_rsp = status_word;
            next_rsp[RSP_ADR_LSB +: 4] = bus_address;
        end else begin
            next_rsp = status_word;
        end
    end

    // The response reports state before this command takes effect.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.rsp_valid <= 1'b0;
            link.rsp_long  <= 1'b0;
            link.rsp_data  <= '0;
        end else begin
            link.rsp_valid <= act;
            if (act) begin
                link.rsp_long <= link.cmd_long;
                link.rsp_data <= next_rsp;
            end
        end
    end
endmodule

/* File: logic/sesl_controller.sv */
`timescale 1ns/1ps
module sesl_controller
    import sesl_pkg::*;
(
    sesl_link_if.ctl          link,
    input  wire logic [3:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [3:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready
);
    logic        aclk;
    logic        aresetn;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        wr_cmd;
    logic        rsp_seen;
    logic        no_answer;
    logic [2:0]  wait_cnt;
    logic        waiting;
    logic        last_long;
    logic [15:0] last_rsp;

    assign aclk    = link.aclk;
    assign aresetn = link.aresetn;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    // The strobes are taken with the data; the master may drop them after.
    assign wr_cmd  = wr_fire && aw_addr == REG_CMD && w_strb != 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == REG_CMD) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // A write to the command register with any strobe set sends one command frame.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.cmd_valid <= 1'b0;
            link.cmd_long  <= 1'b0;
            link.cmd_code  <= '0;
            link.cmd_addr  <= '0;
            link.cmd_data  <= '0;
        end else begin
            link.cmd_valid <= wr_cmd;
            if (wr_cmd) begin
                link.cmd_code <= w_data[CMD_CODE_LSB +: 4];
                link.cmd_addr <= w_data[CMD_ADDR_LSB +: 4];
                link.cmd_data <= w_data[CMD_DATA_LSB +: 8];
                link.cmd_long <= w_data[CMD_LONG_BIT];
            end
        end
    end

    // A silent device leaves no answer; software must then re-initialize.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waiting   <= 1'b0;
            wait_cnt  <= '0;
            no_answer <= 1'b0;
        end else if (link.cmd_valid) begin
            waiting   <= 1'b1;
            wait_cnt  <= '0;
            no_answer <= 1'b0;
        end else if (waiting && link.rsp_valid) begin
            waiting <= 1'b0;
        end else if (waiting && wait_cnt == NO_ANSWER_WAIT) begin
            waiting   <= 1'b0;
            no_answer <= 1'b1;
        end else if (waiting) begin
            wait_cnt <= wait_cnt + 1'b1;
        end
    end

    // A new answer wins over the clear made by a new command.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_seen  <= 1'b0;
            last_long <= 1'b0;
            last_rsp  <= '0;
        end else if (link.rsp_valid) begin
            rsp_seen  <= 1'b1;
            last_long <= link.rsp_long;
            last_rsp  <= link.rsp_data;
        end else if (wr_cmd) begin
            rsp_seen <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= AXI_OKAY;
            s_axi_rdata  <= '0;
            unique case (s_axi_araddr)
                REG_STATUS: begin
                    s_axi_rdata[STS_RSP_BIT]   <= rsp_seen;
                    s_axi_rdata[STS_NOANS_BIT] <= no_answer;
                    s_axi_rdata[STS_LONG_BIT]  <= last_long;
                end
                REG_RSP: s_axi_rdata <= {16'h0000, last_rsp};
                REG_CMD: s_axi_rdata <= '0;
                default: s_axi_rresp <= AXI_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* File: verification/sesl_link_asserts.sv */
`timescale 1ns/1ps
module sesl_link_asserts
    import sesl_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        cmd_valid,
    input wire logic        cmd_long,
    input wire logic [3:0]  cmd_code,
    input wire logic [3:0]  cmd_addr,
    input wire logic [7:0]  cmd_data,
    input wire logic        rsp_valid,
    input wire logic        rsp_long,
    input wire logic [15:0] rsp_data
);
    logic [3:0] ans_code;
    logic       last_dis;
    logic       is_stat;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Code of the command that the next answer belongs to.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ans_code <= 4'h0;
        end else if (cmd_valid) begin
            ans_code <= cmd_code;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_dis <= 1'b0;
        end else if (rsp_valid) begin
            last_dis <= (ans_code == CMD_DISABLE_ST);
        end
    end

    // Acceleration reads carry data, so only status answers have their fields judged.
    assign is_stat = rsp_valid && (ans_code != CMD_READ_ACCEL);

    skip_code_e_a: assert property (cmd_valid && cmd_code == CMD_UNUSED_14
        |=> !rsp_valid) else $error("answer to code E");
    skip_code_f_a: assert property (cmd_valid && cmd_code == CMD_REV_INIT
        |=> !rsp_valid) else $error("answer to code F");
    rsp_needs_cmd_a: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("answer without command");
    rsp_format_a: assert property (rsp_valid |-> rsp_long == $past(cmd_long))
        else $error("answer format differs");
    long_addr_a: assert property (is_stat && rsp_long
        |-> rsp_data[15:12] == $past(cmd_addr))
        else $error("long answer address wrong");
    short_zero_a: assert property (is_stat && !rsp_long
        |-> rsp_data[15:8] == 8'h00 && rsp_data[4] == 1'b0)
        else $error("short answer spare bits set");
    st_error_a: assert property (is_stat && rsp_data[RSP_ST_BIT]
        && !rsp_data[RSP_U_BIT] |-> rsp_data[RSP_S_BIT])
        else $error("self-test without error flag");
    dis_clears_st_a: assert property (is_stat && last_dis
        |-> !rsp_data[RSP_ST_BIT])
        else $error("self-check flag after disable");

    cover property (is_stat && rsp_data[RSP_ST_BIT]);
    cover property (is_stat && rsp_long);
    cover property (is_stat && rsp_data[RSP_U_BIT]);
endmodule

/* File: verification/test_sensor_exception_status_logic.sv */
`timescale 1ns/1ps
module test_sensor_exception_status_logic;
    import sesl_pkg::*;
    localparam logic [3:0]  DEV = 4'h5;
    localparam logic [15:0] NORM = 16'h1234;
    localparam logic [15:0] SELF = 16'h5A5A;
    localparam logic [31:0] SH = 32'h1;
    localparam logic [31:0] LG = 32'h5;
    localparam logic [31:0] NO = 32'h2;
    localparam logic [3:0]  FLT [4] = '{4'h3, 4'hC, 4'h1, 4'h4};
    logic        aclk;
    logic        aresetn;
    logic [4:0]  sil;
    logic [3:0]  flt;
    logic        nv;
    logic [7:0]  cfg;
    logic [3:0]  adr;
    logic        st_drive;
    logic        in_rst;
    logic [3:0]  awaddr;
    logic [3:0]  araddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [1:0]  rr;
    logic [31:0] sts;
    logic [31:0] rsp;
    logic        prev_lg;
    int          num_errors;
    int          num_checks;

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    sesl_link_if u_sesl_link_if (.aclk(aclk), .aresetn(aresetn));

    sesl_device #(.HOLD_CAP_PIN_CYC(200), .CTEST_CYC(150), .IDLE_CYC(120))
    u_sesl_device (
        .link(u_sesl_link_if.dev), .vreg_low(sil[0]), .vrega_low(sil[1]),
        .hold_cap_pin(sil[2]), .cap_test_fail(sil[3]),
        .line_input_pin(sil[4]), .factory_crc_fail(flt[0]),
        .factory_seal(flt[1]), .user_mismatch(flt[2]), .user_seal(flt[3]),
        .otp_write_enabled_flag(nv), .device_config_one(cfg),
        .bus_address(adr), .accel_normal(NORM), .accel_self_test(SELF),
        .self_test_drive(st_drive), .core_in_reset(in_rst));

    sesl_controller u_sesl_controller (
        .link(u_sesl_link_if.ctl), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    sesl_link_asserts u_sesl_link_asserts (
        .aclk(aclk), .aresetn(aresetn),
        .cmd_valid(u_sesl_link_if.cmd_valid),
        .cmd_long(u_sesl_link_if.cmd_long),
        .cmd_code(u_sesl_link_if.cmd_code),
        .cmd_addr(u_sesl_link_if.cmd_addr),
        .cmd_data(u_sesl_link_if.cmd_data),
        .rsp_valid(u_sesl_link_if.rsp_valid),
        .rsp_long(u_sesl_link_if.rsp_long),
        .rsp_data(u_sesl_link_if.rsp_data));

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] ew(input logic s, input logic st,
                                       input logic u, input logic lg);
        ew = {16'h0, lg ? adr : 4'h0, 4'h0, nv, u, st, 1'b0, cfg[1:0],
              s, 1'b0};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] eb);
        logic       aw_ok;
        logic       w_ok;
        logic       aw_go;
        logic       w_go;
        logic [1:0] resp;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Ready is judged between edges, where it stands settled.
        while (!(aw_ok && w_ok)) begin
            @(negedge aclk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            @(posedge aclk);
            if (aw_go) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (w_go) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(negedge aclk); while (!bvalid);
        resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
        chk({30'h0, resp}, {30'h0, eb});
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // The controller flags a missing answer six cycles after the command.
    task automatic cmd(input logic [3:0] c, input logic [3:0] a,
                       input logic lg, input logic [31:0] es,
                       input logic [31:0] er);
        logic [31:0] exp_s;
        exp_s = es;
        wr(REG_CMD, {15'h0, lg, 8'h00, a, c}, AXI_OKAY);
        repeat (6) @(posedge aclk);
        rd(REG_STATUS, sts, rr);
        // A missed answer leaves the format bit of the last answer standing.
        if (!es[STS_RSP_BIT]) begin
            exp_s[STS_LONG_BIT] = prev_lg;
        end
        prev_lg = exp_s[STS_LONG_BIT];
        chk(sts, exp_s);
        if (es[STS_RSP_BIT]) begin
            rd(REG_RSP, rsp, rr);
            chk(rsp, er);
        end
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_of_test;
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        prev_lg = 1'b0;
        aresetn <= 1'b0;
        sil <= 5'h00;
        flt <= 4'h0;
        nv <= 1'b1;
        cfg <= 8'hA6;
        adr <= DEV;
        {awaddr, araddr, wstrb, wdata} <= '0;
        {awvalid, wvalid, bready, arvalid, rready} <= '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        cmd(CMD_DISABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        cmd(CMD_DISABLE_ST, DEV, 1'b1, LG, ew(0, 0, 0, 1));
        $display("response format test done");
        cmd(CMD_UNUSED_14, DEV, 1'b0, NO, 32'h0);
        cmd(CMD_REV_INIT, DEV, 1'b1, NO, 32'h0);
        cmd(CMD_CLEAR, 4'h3, 1'b0, NO, 32'h0);
        wr(REG_STATUS, 32'h0, AXI_SLVERR);
        rd(4'hC, sts, rr);
        chk({rr, sts[29:0]}, {AXI_SLVERR, 30'h0});
        $display("ignored command test done");
        cmd(CMD_ENABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        cmd(CMD_READ_ACCEL, DEV, 1'b0, SH, {16'h0, NORM});
        chk({31'h0, st_drive}, 32'h0);
        cmd(CMD_CLEAR, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        cmd(CMD_ENABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        chk({31'h0, st_drive}, 32'h1);
        cmd(CMD_READ_ACCEL, DEV, 1'b0, SH, {16'h0, SELF});
        cmd(CMD_READ_ACCEL, DEV, 1'b1, LG, {16'h0, SELF});
        cmd(CMD_DISABLE_ST, DEV, 1'b0, SH, ew(1, 1, 0, 0));
        cmd(CMD_ENABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        cmd(CMD_DISABLE_ST, DEV, 1'b0, SH, ew(1, 1, 0, 0));
        cmd(CMD_ENABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        chk({31'h0, st_drive}, 32'h1);
        $display("self-test lockout test done");
        sil <= 5'h04;
        repeat (4) @(posedge aclk);
        cmd(CMD_READ_ACCEL, DEV, 1'b0, SH, {16'h0, SELF});
        cmd(CMD_DISABLE_ST, DEV, 1'b0, SH, ew(0, 1, 1, 0));
        cmd(CMD_READ_ACCEL, DEV, 1'b0, SH, 32'h0);
        cmd(CMD_READ_ACCEL, DEV, 1'b1, LG, {16'h0, NORM});
        cmd(CMD_CLEAR, DEV, 1'b0, SH, ew(0, 0, 1, 0));
        sil <= 5'h00;
        repeat (4) @(posedge aclk);
        cmd(CMD_CLEAR, DEV, 1'b1, LG, ew(0, 0, 0, 1));
        $display("capacitor dip test done");
        nv <= 1'b0;
        cfg <= 8'h55;
        for (int i = 0; i < 4; i++) begin
            flt <= FLT[i];
            repeat (4) @(posedge aclk);
            cmd(CMD_CLEAR, DEV, 1'b0, SH, ew(i < 2, 0, 0, 0));
            cmd(CMD_READ_ACCEL, DEV, 1'b0, SH,
                {16'h0, i < 2 ? 16'h0 : NORM});
            cmd(CMD_READ_ACCEL, DEV, 1'b1, LG, {16'h0, NORM});
        end
        flt <= 4'h0;
        $display("fuse fault test done");
        cmd(CMD_DISABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        cmd(CMD_DISABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        // Waiting past the longest interval puts every source in silence.
        for (int i = 0; i < 5; i++) begin
            sil <= 5'h01 << i;
            repeat (250) @(posedge aclk);
            chk({31'h0, in_rst}, 32'h1);
            cmd(CMD_CLEAR, DEV, 1'b0, NO, 32'h0);
            sil <= 5'h00;
            repeat (6) @(posedge aclk);
            cmd(CMD_READ_ACCEL, DEV, 1'b0, SH, {16'h0, NORM});
        end
        cmd(CMD_ENABLE_ST, DEV, 1'b0, SH, ew(0, 0, 0, 0));
        chk({31'h0, st_drive}, 32'h1);
        cmd(CMD_CLEAR, DEV, 1'b0, SH, ew(1, 1, 0, 0));
        adr <= GLOBAL_ADDR;
        cmd(CMD_ENABLE_ST, GLOBAL_ADDR, 1'b0, SH, ew(0, 0, 0, 0));
        chk({31'h0, st_drive}, 32'h0);
        adr <= DEV;
        $display("silent reset test done");
        end_of_test;
    end
endmodule
